// file: src/gpx_pkg.sv
// shared constants and types for the two-wire gpio expander
`default_nettype none
package gpx_pkg;
  // command codes (register pointer values)
  localparam logic [7:0] CMD_IN_LO = 8'h00;
  localparam logic [7:0] CMD_IN_HI = 8'h01;
  localparam logic [7:0] CMD_OUT_LO = 8'h02;
  localparam logic [7:0] CMD_OUT_HI = 8'h03;
  localparam logic [7:0] CMD_INV_LO = 8'h04;
  localparam logic [7:0] CMD_INV_HI = 8'h05;
  localparam logic [7:0] CMD_DIR_LO = 8'h06;
  localparam logic [7:0] CMD_DIR_HI = 8'h07;
  localparam logic [7:0] CMD_WDOG = 8'h08;
  localparam logic [7:0] CMD_FACTORY = 8'hff;
  // pointer bits [2:1] pick the register pair, bit 0 the port
  localparam logic [1:0] GRP_IN = 2'h0;
  localparam logic [1:0] GRP_OUT = 2'h1;
  localparam logic [1:0] GRP_INV = 2'h2;
  localparam logic [1:0] GRP_DIR = 2'h3;
  localparam logic [7:0] PAIR_FLIP = 8'h01;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // reset values
  localparam logic [7:0] RST_OUT = 8'hff;
  localparam logic [7:0] RST_INV = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_WDOG = 8'h01;
  localparam logic [7:0] RST_SNAP = 8'hff;
  localparam int WDOG_EN_BIT = 0;
  // serial framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic DRIVE_LOW = 1'b0;
  // bus watchdog time
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int TIMEOUT_MS = 29;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_FREQ_HZ / 1000);
  // address strap classes
  localparam logic [1:0] PIN_GND = 2'h0;
  localparam logic [1:0] PIN_VDD = 2'h1;
  localparam logic [1:0] PIN_SCL = 2'h2;
  localparam logic [1:0] PIN_SDA = 2'h3;
  localparam logic ADDR_TOP_DEFAULT = 1'b0;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_CMD, ST_ACK_CMD,
    ST_WDATA, ST_ACK_WDATA, ST_RDATA, ST_ACK_RDATA
  } gpx_state_e;
endpackage
`default_nettype wire

// file: src/gpx_sync.sv
// two-flop synchroniser for a vector of asynchronous levels
`default_nettype none
module gpx_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } gpx_sync_s;

  gpx_sync_s st_ff;
  gpx_sync_s nxt_st;

  // first stage feeds only the second
  always_comb begin
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;
endmodule // gpx_sync
`default_nettype wire

// file: src/gpx_link_sampler.sv
// data bit capture on the serial clock, handed over by a toggle
`default_nettype none
module gpx_link_sampler (
  input wire logic scl,
  input wire logic rst_n,
  input wire logic sda_in,
  output logic bit_val,
  output logic bit_tgl
);
  typedef struct packed {
    logic bit_val;
    logic tgl;
  } gpx_link_s;

  gpx_link_s st_ff;
  gpx_link_s nxt_st;

  // the bit stays put until the next rising edge, microseconds later,
  // so the system side may read it once the toggle has crossed
  always_comb begin
    nxt_st.bit_val = sda_in;
    nxt_st.tgl = ~st_ff.tgl;
  end

  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bit_val = st_ff.bit_val;
  assign bit_tgl = st_ff.tgl;
endmodule // gpx_link_sampler
`default_nettype wire

// file: src/gpx_expander.sv
// two-wire slave gpio expander: protocol engine, registers, interrupt
`default_nettype none
// Contract
// - Data falling while clock high is a start condition.
// - Data rising while clock high is a stop; bus becomes free.
// - One bit per clock pulse; data steady while clock is high.
// - Ninth pulse is acknowledge; receiver holds data low.
// - Device acknowledges written bytes; master acknowledges read bytes.
// - First byte: seven address bits then direction bit, low means write.
// - Address comes from three four-way strap pins; answer own address only.
// - Byte after address in a write is latched as register pointer.
// - Codes 0-7 select the four register pairs, 8 the watchdog register.
// - After each written byte the pointer flips to the pair partner.
// - Any number of written bytes are stored until stop.
// - Written byte commits at the falling edge of its acknowledge pulse.
// - Each further read byte comes from the pair partner, endlessly.
// - Interrupt asserts on input pin change; output pins never cause it.
// - Interrupt clears on return to old level or read of that port.
// - Interrupt clearing is tracked per eight-bit port.
// - Switching output to input may raise a false interrupt.
// - Input registers show pin levels in any direction, latched on read.
// - Writes to input registers are discarded.
// - Input pins are undriven; output pins follow their output bit.
// - Reset: outputs and directions ones, inversion zeros, watchdog one.
// - Direction bit one makes the pin an input, zero an output.
// - Inversion bit set inverts the pin level seen in input register.
// - Reading an output register returns the stored value.
// - With watchdog enabled, a line low past 29 ms resets the interface.
module gpx_expander
  import gpx_pkg::*;
#(
  parameter int TMO_CYCLES = TIMEOUT_CYC,
  parameter logic ADDR_TOP = ADDR_TOP_DEFAULT
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic addr_select_0,
  input wire logic addr_select_1,
  input wire logic addr_select_2,
  input wire logic [15:0] port_pins_in,
  output logic [15:0] port_pins_out,
  output logic [15:0] port_pins_oe_n,
  input wire logic irq_n_in,
  output logic irq_n_out,
  output logic irq_n_oe_n
);
  localparam int TW = $clog2(TMO_CYCLES + 1);
  localparam int SYNC_W = 21;

  typedef struct packed {
    gpx_state_e state;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic rw;
    logic mack;
    logic [1:0][7:0] outp;
    logic [1:0][7:0] inv;
    logic [1:0][7:0] dir;
    logic [7:0] wdog;
    logic [1:0][7:0] snap;
    logic sda_rel;
    logic irq_rel;
    logic scl_d;
    logic sda_d;
    logic tgl_d;
    logic [2:0] idle_smp;
    logic [2:0] start_smp;
    logic [2:0] fall_smp;
    logic [TW-1:0] tmo;
  } gpx_core_s;

  localparam gpx_core_s CORE_RST = '{
    state: ST_IDLE,
    outp: {RST_OUT, RST_OUT},
    inv: {RST_INV, RST_INV},
    dir: {RST_DIR, RST_DIR},
    wdog: RST_WDOG,
    snap: {RST_SNAP, RST_SNAP},
    sda_rel: 1'b1,
    irq_rel: 1'b1,
    scl_d: 1'b1,
    sda_d: 1'b1,
    default: '0
  };

  gpx_core_s st_ff;
  gpx_core_s nxt_st;

  logic [SYNC_W-1:0] in_s;
  logic scl_s;
  logic sda_s;
  logic [2:0] ads;
  logic [1:0][7:0] pins_s;
  logic link_bit;
  logic link_tgl;
  logic tgl_s;
  logic rise_ev;
  logic fall_ev;
  logic start_ev;
  logic stop_ev;
  logic tmo_hit;
  logic [6:0] my_addr;
  logic [1:0] irq_pend;

  // every pin passes two flops before the engine looks at it
  gpx_sync #(
    .W(SYNC_W),
    .RST_VAL({5'h1f, 16'hffff})
  ) u_pin_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({scl, sda_in, addr_select_2, addr_select_1, addr_select_0, port_pins_in}),
    .q(in_s)
  );

  assign {scl_s, sda_s, ads, pins_s} = in_s;

  // data bits are taken on the serial clock itself
  gpx_link_sampler u_link (
    .scl(scl),
    .rst_n(rst_n),
    .sda_in(sda_in),
    .bit_val(link_bit),
    .bit_tgl(link_tgl)
  );

  gpx_sync #(
    .W(1),
    .RST_VAL(1'b0)
  ) u_tgl_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d(link_tgl),
    .q(tgl_s)
  );

  // bus events; start and stop come from synchronised levels
  assign rise_ev = tgl_s ^ st_ff.tgl_d;
  assign fall_ev = st_ff.scl_d & ~scl_s;
  assign start_ev = scl_s & st_ff.scl_d & st_ff.sda_d & ~sda_s;
  assign stop_ev = scl_s & st_ff.scl_d & ~st_ff.sda_d & sda_s;

  // strap class from samples taken at idle, at start and at first low clock
  function automatic logic [1:0] pin_class(input logic idle_v, input logic start_v,
                                           input logic fall_v);
    logic [1:0] c;
    c = PIN_SDA;
    if (!idle_v) begin
      c = PIN_GND;
    end else if (fall_v) begin
      c = PIN_VDD;
    end else if (start_v) begin
      c = PIN_SCL;
    end
    return c;
  endfunction

  // own address: one fixed top bit and three two-bit strap codes
  always_comb begin
    my_addr[6] = ADDR_TOP;
    for (int i = 0; i < 3; i++) begin
      my_addr[2*i +: 2] = pin_class(st_ff.idle_smp[i], st_ff.start_smp[i],
                                    st_ff.fall_smp[i]);
    end
  end

  // partner register within a pair; the watchdog register has none
  function automatic logic [7:0] pair_of(input logic [7:0] p);
    return (p < CMD_WDOG) ? (p ^ PAIR_FLIP) : p;
  endfunction

  // register read mux
  function automatic logic [7:0] rd_byte(input logic [7:0] p, input gpx_core_s s,
                                         input logic [1:0][7:0] pins);
    logic [7:0] v;
    v = RD_UNMAPPED;
    if (p == CMD_WDOG) begin
      v = s.wdog;
    end else if (p < CMD_WDOG) begin
      case (p[2:1])
        GRP_IN: v = pins[p[0]] ^ s.inv[p[0]];
        GRP_OUT: v = s.outp[p[0]];
        GRP_INV: v = s.inv[p[0]];
        default: v = s.dir[p[0]];
      endcase
    end
    return v;
  endfunction

  // load a read byte; reading an input port refreshes its snapshot
  function automatic gpx_core_s load_tx(input gpx_core_s s, input logic [7:0] p,
                                        input logic [1:0][7:0] pins);
    gpx_core_s r;
    r = s;
    r.tx = rd_byte(p, s, pins);
    if (p < CMD_OUT_LO) begin
      r.snap[p[0]] = pins[p[0]];
    end
    r.sda_rel = r.tx[7];
    r.state = ST_RDATA;
    r.cnt = '0;
    return r;
  endfunction

  // interrupt pending per port: input-configured pins off their snapshot;
  // a pin just turned to input may differ and fire at once, as intended
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      irq_pend[p] = |((pins_s[p] ^ st_ff.snap[p]) & st_ff.dir[p]);
    end
  end

  // protocol engine, register writes and watchdog
  always_comb begin
    nxt_st = st_ff;
    nxt_st.scl_d = scl_s;
    nxt_st.sda_d = sda_s;
    nxt_st.tgl_d = tgl_s;
    nxt_st.irq_rel = ~|irq_pend;
    tmo_hit = 1'b0;

    // strap samples: idle bus, start condition
    if (scl_s && sda_s && st_ff.state == ST_IDLE) begin
      nxt_st.idle_smp = ads;
    end
    if (start_ev) begin
      nxt_st.start_smp = ads;
    end

    // watchdog runs only inside a transfer while a line sits low
    if (st_ff.state == ST_IDLE || (scl_s && sda_s) || !st_ff.wdog[WDOG_EN_BIT]) begin
      nxt_st.tmo = '0;
    end else if (st_ff.tmo >= TW'(TMO_CYCLES)) begin
      tmo_hit = 1'b1;
    end else begin
      nxt_st.tmo = st_ff.tmo + TW'(1);
    end

    case (st_ff.state)
      ST_IDLE: begin
        nxt_st.sda_rel = 1'b1;
      end
      ST_ADDR, ST_CMD, ST_WDATA: begin
        if (rise_ev) begin
          nxt_st.shift = {st_ff.shift[6:0], link_bit};
          nxt_st.cnt = st_ff.cnt + 4'h1;
        end
        if (fall_ev && st_ff.state == ST_ADDR && st_ff.cnt == '0) begin
          nxt_st.fall_smp = ads;
        end
        if (fall_ev && st_ff.cnt == BYTE_BITS) begin
          nxt_st.cnt = '0;
          case (st_ff.state)
            ST_ADDR: begin
              if (st_ff.shift[7:1] == my_addr) begin
                nxt_st.rw = st_ff.shift[0];
                nxt_st.sda_rel = 1'b0;
                nxt_st.state = ST_ACK_ADDR;
              end else begin
                nxt_st.state = ST_IDLE;
              end
            end
            ST_CMD: begin
              nxt_st.sda_rel = 1'b0;
              nxt_st.state = ST_ACK_CMD;
            end
            default: begin
              nxt_st.sda_rel = 1'b0;
              nxt_st.state = ST_ACK_WDATA;
            end
          endcase
        end
      end
      ST_ACK_ADDR: begin
        if (fall_ev) begin
          nxt_st.sda_rel = 1'b1;
          if (st_ff.rw) begin
            nxt_st = load_tx(nxt_st, st_ff.ptr, pins_s);
          end else begin
            nxt_st.state = ST_CMD;
          end
        end
      end
      ST_ACK_CMD: begin
        if (fall_ev) begin
          nxt_st.sda_rel = 1'b1;
          nxt_st.ptr = st_ff.shift;
          nxt_st.state = ST_WDATA;
        end
      end
      ST_ACK_WDATA: begin
        if (fall_ev) begin
          nxt_st.sda_rel = 1'b1;
          // commit on the falling edge that ends the acknowledge pulse
          if (st_ff.ptr == CMD_WDOG) begin
            nxt_st.wdog = st_ff.shift;
          end else if (st_ff.ptr < CMD_WDOG) begin
            case (st_ff.ptr[2:1])
              GRP_IN: nxt_st.snap = st_ff.snap;
              GRP_OUT: nxt_st.outp[st_ff.ptr[0]] = st_ff.shift;
              GRP_INV: nxt_st.inv[st_ff.ptr[0]] = st_ff.shift;
              default: nxt_st.dir[st_ff.ptr[0]] = st_ff.shift;
            endcase
          end
          nxt_st.ptr = pair_of(st_ff.ptr);
          nxt_st.state = ST_WDATA;
        end
      end
      ST_RDATA: begin
        if (rise_ev) begin
          nxt_st.cnt = st_ff.cnt + 4'h1;
        end
        if (fall_ev) begin
          if (st_ff.cnt == BYTE_BITS) begin
            nxt_st.sda_rel = 1'b1;
            nxt_st.cnt = '0;
            nxt_st.state = ST_ACK_RDATA;
          end else begin
            nxt_st.tx = {st_ff.tx[6:0], 1'b0};
            nxt_st.sda_rel = st_ff.tx[6];
          end
        end
      end
      ST_ACK_RDATA: begin
        if (rise_ev) begin
          nxt_st.mack = link_bit;
        end
        if (fall_ev) begin
          if (!st_ff.mack) begin
            nxt_st.ptr = pair_of(st_ff.ptr);
            nxt_st = load_tx(nxt_st, pair_of(st_ff.ptr), pins_s);
          end else begin
            nxt_st.sda_rel = 1'b1;
            nxt_st.state = ST_IDLE;
          end
        end
      end
      default: begin
        nxt_st.state = ST_IDLE;
      end
    endcase

    // bus conditions and watchdog override the byte engine
    if (stop_ev || tmo_hit) begin
      nxt_st.state = ST_IDLE;
      nxt_st.sda_rel = 1'b1;
      nxt_st.cnt = '0;
    end else if (start_ev) begin
      nxt_st.state = ST_ADDR;
      nxt_st.sda_rel = 1'b1;
      nxt_st.cnt = '0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= CORE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // open-drain lines only ever pull low; the enable decides
  assign sda_out = DRIVE_LOW;
  assign sda_oe_n = st_ff.sda_rel;
  assign irq_n_out = DRIVE_LOW;
  assign irq_n_oe_n = st_ff.irq_rel;
  // direction one turns both drivers off
  assign port_pins_out = {st_ff.outp[1], st_ff.outp[0]};
  assign port_pins_oe_n = {st_ff.dir[1], st_ff.dir[0]};
endmodule // gpx_expander
`default_nettype wire

// file: testbench/gpx_master_model.sv
// two-wire bus master model for the expander bench
`default_nettype none
module gpx_master_model (
  input wire logic clock,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  // one bus phase, well above the three-cycle answer delay of the device
  task automatic tick();
    repeat (15) @(posedge clock);
  endtask
  // also serves as repeated start, since it releases data first
  task automatic start();
    sda_low <= 1'h0;
    tick();
    scl <= 1'h1;
    tick();
    sda_low <= 1'h1;
    tick();
    scl <= 1'h0;
    tick();
  endtask
  task automatic stop();
    sda_low <= 1'h1;
    tick();
    scl <= 1'h1;
    tick();
    sda_low <= 1'h0;
    tick();
  endtask
  // data only moves while the clock is low
  task automatic bitx(input logic b, output logic r);
    sda_low <= !b;
    tick();
    scl <= 1'h1;
    tick();
    r = sda_line;
    scl <= 1'h0;
    tick();
  endtask
  // also called with the unmapped pointer code 8'h09
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'h1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'h1, r);
      d[i] = r;
    end
    bitx(!ack, r);
  endtask
endmodule // gpx_master_model
`default_nettype wire

// file: testbench/gpx_expander_monitor.sv
// pin-level assertions for the expander
`default_nettype none
module gpx_expander_monitor #(
  parameter int TMO_CYCLES = 200
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic [15:0] port_pins_out,
  input wire logic [15:0] port_pins_oe_n,
  input wire logic irq_n_out,
  input wire logic irq_n_oe_n
);
  logic [15:0] low_cnt_ff;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // cycles with a bus line low; saturates so it never wraps to zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) low_cnt_ff <= 16'h0;
    else if (scl && sda_in) low_cnt_ff <= 16'h0;
    else if (low_cnt_ff != 16'hffff) low_cnt_ff <= low_cnt_ff + 16'h1;
  end
  sequence s_drive_low;
    (!sda_oe_n && !scl) [*6];
  endsequence
  sequence s_commit;
    $rose(sda_oe_n) && !scl;
  endsequence
  drive_const_a: assert property (!sda_out && !irq_n_out)
    else $error("open drain level not low");
  reset_vals_a: assert property ($rose(rst_n) |-> port_pins_out == 16'hffff &&
    port_pins_oe_n == 16'hffff && sda_oe_n && irq_n_oe_n)
    else $error("reset values wrong");
  ack_hold_a: assert property ($fell(sda_oe_n) |-> s_drive_low)
    else $error("data pull not held");
  data_steady_a: assert property ($changed(sda_oe_n) |-> !scl)
    else $error("data moved with clock high");
  out_commit_a: assert property ($changed(port_pins_out) |-> s_commit)
    else $error("output changed off acknowledge fall");
  dir_commit_a: assert property ($changed(port_pins_oe_n) |-> s_commit)
    else $error("direction changed off acknowledge fall");
  out_no_irq_a: assert property ((port_pins_oe_n == 16'h0) [*6] |-> irq_n_oe_n)
    else $error("interrupt with all pins outputs");
  bus_wdog_a: assert property (int'(low_cnt_ff) > TMO_CYCLES + 8 |-> sda_oe_n)
    else $error("data held past bus timeout");
endmodule // gpx_expander_monitor
bind gpx_expander gpx_expander_monitor #(.TMO_CYCLES(TMO_CYCLES)) u_mon (
  .clock, .rst_n, .scl, .sda_in, .sda_out, .sda_oe_n,
  .port_pins_out, .port_pins_oe_n, .irq_n_out, .irq_n_oe_n
);
`default_nettype wire

// file: testbench/tb_gpx_expander.sv
// self-checking bench for the two-wire gpio expander
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_gpx_expander
  import gpx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // short watchdog count so the timeout test stays brief
  localparam int TMO = 2000;
  localparam logic [6:0] DEV = 7'h11;
  localparam logic [7:0] AW = {DEV, 1'h0};
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic [15:0] ext = 16'hffff;
  int fails = 0;
  int samples_checked = 0;
  logic m_scl, m_low, ack, sda_oe_n, irq_n_oe_n;
  logic [7:0] rd_q [2];
  logic [15:0] pins_out, pins_oe_n;
  // pulled-up data wire: anyone pulling low wins; port pins take the device drive where enabled
  wire logic sda_w = !(m_low || !sda_oe_n);
  wire logic [15:0] pins_w = (pins_out & ~pins_oe_n) | (ext & pins_oe_n);
  always #5 clock = ~clock;
  gpx_expander #(.TMO_CYCLES(TMO)) u_dut (
    .clock(clock), .rst_n(rst_n), .scl(m_scl), .sda_in(sda_w), .sda_out(),
    .sda_oe_n(sda_oe_n), .addr_select_0(1'h1), .addr_select_1(1'h0),
    .addr_select_2(1'h1), .port_pins_in(pins_w), .port_pins_out(pins_out),
    .port_pins_oe_n(pins_oe_n), .irq_n_in(irq_n_oe_n), .irq_n_out(),
    .irq_n_oe_n(irq_n_oe_n));
  gpx_master_model u_mst (.clock(clock), .sda_line(sda_w), .scl(m_scl), .sda_low(m_low));
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d [$]);
    u_mst.start();
    u_mst.wbyte(AW, ack);
    `CHK("addr ack", 1'h1, ack)
    u_mst.wbyte(cmd, ack);
    `CHK("cmd ack", 1'h1, ack)
    foreach (d[i]) begin
      u_mst.wbyte(d[i], ack);
      `CHK("data ack", 1'h1, ack)
    end
    u_mst.stop();
  endtask
  task automatic rd(input logic [7:0] cmd, input int n);
    u_mst.start();
    u_mst.wbyte(AW, ack);
    u_mst.wbyte(cmd, ack);
    u_mst.start();
    u_mst.wbyte({DEV, 1'h1}, ack);
    `CHK("read addr ack", 1'h1, ack)
    for (int i = 0; i < n; i++) u_mst.rbyte(i < n - 1, rd_q[i]);
    u_mst.stop();
  endtask
  task automatic rchk(input logic [7:0] cmd, input logic [7:0] e0, input logic [7:0] e1);
    rd(cmd, 2);
    `CHK("read byte 0", e0, rd_q[0])
    `CHK("read byte 1", e1, rd_q[1])
  endtask
  // single byte read, then the interrupt level once the interface settles
  task automatic rd1(input logic [7:0] cmd, input logic [7:0] e, input logic irq);
    rd(cmd, 1);
    repeat (10) @(posedge clock);
    `CHK("read byte", e, rd_q[0])
    `CHK("interrupt", irq, irq_n_oe_n)
  endtask
  task automatic pins(input logic [15:0] v, input logic irq);
    ext <= v;
    repeat (10) @(posedge clock);
    `CHK("interrupt", irq, irq_n_oe_n)
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'h1;
    repeat (10) @(posedge clock);
    rchk(CMD_OUT_LO, RST_OUT, RST_OUT);
    rchk(CMD_INV_LO, RST_INV, RST_INV);
    rchk(CMD_DIR_LO, RST_DIR, RST_DIR);
    rchk(CMD_WDOG, RST_WDOG, RST_WDOG);
    $display("test reset values done");
    wr(CMD_OUT_HI, '{8'ha5, 8'h3c, 8'h0f});
    rchk(CMD_OUT_LO, 8'h3c, 8'h0f);
    wr(CMD_IN_LO, '{8'h55});
    rchk(CMD_OUT_HI, 8'h0f, 8'h3c);
    rchk(8'h09, RD_UNMAPPED, RD_UNMAPPED);
    $display("test pair walk done");
    wr(CMD_DIR_LO, '{8'h00, 8'h00});
    `CHK("drive enables", 16'h0000, pins_oe_n)
    `CHK("pin drive", 16'h0f3c, pins_out)
    pins(16'h0000, 1'h1);
    rchk(CMD_IN_LO, 8'h3c, 8'h0f);
    wr(CMD_INV_LO, '{8'hff, 8'h00});
    rchk(CMD_IN_LO, 8'hc3, 8'h0f);
    $display("test direction and inversion done");
    // snapshot now 3c/0f; pin 3 low outside gives a false interrupt
    ext <= 16'h0f34;
    wr(CMD_DIR_LO, '{8'hff, 8'hff});
    `CHK("interrupt", 1'h0, irq_n_oe_n)
    rd1(CMD_IN_HI, 8'h0f, 1'h0);
    rd1(CMD_IN_LO, 8'hcb, 1'h1);
    pins(16'h0f3c, 1'h0);
    pins(16'h0f34, 1'h1);
    $display("test interrupt done");
    u_mst.start();
    u_mst.wbyte({7'h12, 1'h0}, ack);
    `CHK("foreign addr ack", 1'h0, ack)
    u_mst.stop();
    // stall the clock low while the device holds its acknowledge
    u_mst.start();
    for (int i = 7; i >= 0; i--) u_mst.bitx(AW[i], ack);
    `CHK("addr ack drive", 1'h0, sda_oe_n)
    repeat (TMO + 30) @(posedge clock);
    `CHK("timeout release", 1'h1, sda_oe_n)
    u_mst.stop();
    rchk(CMD_OUT_LO, 8'h3c, 8'h0f);
    $display("test address and timeout done");
    summarize();
  end
  // cuts a hung run short
  initial begin
    repeat (90000) @(posedge clock);
    fails++;
    summarize();
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
endmodule // tb_gpx_expander
`default_nettype wire
